/* icpm_cfg.svh */
`ifndef ICPM_CFG_SVH
`define ICPM_CFG_SVH

`define ICPM_NSRC 10
`define ICPM_PHASES_LAST 4'hb
`define ICPM_SAMPLE_PHASE 4'h9
`define ICPM_RST_MCYCLES 2'h3

`define ICPM_IDX_POWER_CONTROL 10'h087
`define ICPM_IDX_INTR_ENABLE_SECOND 10'h0a7
`define ICPM_IDX_INTR_ENABLE 10'h0a8
`define ICPM_IDX_INTR_PRIORITY_SECOND 10'h0b7
`define ICPM_IDX_INTR_PRIORITY 10'h0b8
`define ICPM_IDX_STATUS 10'h0c0

`define ICPM_RST_REG 8'h00
`define ICPM_MASK_FIRST_ENABLE 8'hbf
`define ICPM_MASK_FIRST_PRIORITY 8'h3f
`define ICPM_MASK_SECOND 8'h93

`define ICPM_BIT_GLOBAL_ENABLE 7
`define ICPM_BIT_SERIAL1_DOUBLE 7
`define ICPM_BIT_SERIAL2_DOUBLE 6
`define ICPM_BIT_LVR_DISABLE 5
`define ICPM_BIT_ADC_INT_ENABLE 4
`define ICPM_BIT_SERIAL2_RX_CLK 3
`define ICPM_BIT_SERIAL2_TX_CLK 2
`define ICPM_BIT_POWER_DOWN 1
`define ICPM_BIT_IDLE 0

`define ICPM_POS_EXT0 0
`define ICPM_POS_SERIAL2 12
`define ICPM_POS_TIMER0 1
`define ICPM_POS_I2C 9
`define ICPM_POS_EXT1 2
`define ICPM_POS_DDC 15
`define ICPM_POS_TIMER1 3
`define ICPM_POS_USB 8
`define ICPM_POS_SERIAL1 4
`define ICPM_POS_TIMER2 5

`define ICPM_VEC_EXT0 16'h0003
`define ICPM_VEC_SERIAL2 16'h004b
`define ICPM_VEC_TIMER0 16'h000b
`define ICPM_VEC_I2C 16'h0043
`define ICPM_VEC_EXT1 16'h0013
`define ICPM_VEC_DDC 16'h003b
`define ICPM_VEC_TIMER1 16'h001b
`define ICPM_VEC_USB 16'h0033
`define ICPM_VEC_SERIAL1 16'h0023
`define ICPM_VEC_TIMER2 16'h002b

`endif

/* icpm_pkg.sv */
package icpm_pkg;

  typedef enum logic [3:0] {
    PM_RUN = 4'h1,
    PM_IDLE = 4'h2,
    PM_PDOWN = 4'h4,
    PM_RSTWAIT = 4'h8
  } icpm_pm_t;

  typedef logic [3:0] icpm_src_idx_t;
  typedef logic [15:0] icpm_addr_t;

endpackage

/* icpm_poll_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface icpm_poll_if #(parameter int NSRC = 10);
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] hi;
  logic inprog_hi;
  logic inprog_lo;
  logic valid;
  logic grant_hi;
  logic [3:0] idx;
  modport arb (input req, input hi, input inprog_hi, input inprog_lo,
               output valid, output grant_hi, output idx);
  modport top (output req, output hi, output inprog_hi, output inprog_lo,
               input valid, input grant_hi, input idx);
endinterface
`default_nettype wire

/* icpm_arb.sv */
`timescale 1ns/1ps
`default_nettype none
module icpm_arb #(
  parameter int NSRC = 10
) (
  icpm_poll_if.arb p
);
  import icpm_pkg::*;

  logic hv;
  logic lv;
  logic [3:0] hix;
  logic [3:0] lix;

  // Scan downward so the lowest index, first in polling order, wins
  always_comb begin
    hv = 1'b0;
    lv = 1'b0;
    hix = 4'h0;
    lix = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p.req[i] && p.hi[i]) begin
        hv = 1'b1;
        hix = 4'(i);
      end
      if (p.req[i] && !p.hi[i]) begin
        lv = 1'b1;
        lix = 4'(i);
      end
    end
  end

  // High level may preempt a low routine; nothing preempts a high routine
  always_comb begin
    p.valid = 1'b0;
    p.grant_hi = 1'b0;
    p.idx = 4'h0;
    if (hv && !p.inprog_hi) begin
      p.valid = 1'b1;
      p.grant_hi = 1'b1;
      p.idx = hix;
    end else if (lv && !p.inprog_hi && !p.inprog_lo) begin
      p.valid = 1'b1;
      p.idx = lix;
    end
  end
endmodule
`default_nettype wire

/* icpm_top.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "icpm_cfg.svh"
module icpm_top #(
  parameter int NSRC = `ICPM_NSRC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NSRC-1:0] irq_flags,
  input wire logic instr_last_cycle,
  input wire logic instr_blocks_vector,
  input wire logic return_from_interrupt_instr_exec,
  input wire icpm_pkg::icpm_addr_t pc_current,
  input wire logic internal_reset_req,
  output logic ack_valid,
  output icpm_pkg::icpm_addr_t ack_vector,
  output icpm_pkg::icpm_addr_t ack_push_pc,
  output logic cpu_halt,
  output logic osc_stop,
  output logic core_reset_hold,
  output logic serial1_baud_double,
  output logic serial2_baud_double,
  output logic low_voltage_reset_disable,
  output logic adc_interrupt_enable,
  output logic serial2_receive_clock_flag,
  output logic serial2_transmit_clock_flag
);
  import icpm_pkg::*;

  localparam int POS_TAB [10] = '{
    `ICPM_POS_EXT0, `ICPM_POS_SERIAL2, `ICPM_POS_TIMER0, `ICPM_POS_I2C,
    `ICPM_POS_EXT1, `ICPM_POS_DDC, `ICPM_POS_TIMER1, `ICPM_POS_USB,
    `ICPM_POS_SERIAL1, `ICPM_POS_TIMER2
  };
  localparam icpm_addr_t VEC_TAB [10] = '{
    `ICPM_VEC_EXT0, `ICPM_VEC_SERIAL2, `ICPM_VEC_TIMER0, `ICPM_VEC_I2C,
    `ICPM_VEC_EXT1, `ICPM_VEC_DDC, `ICPM_VEC_TIMER1, `ICPM_VEC_USB,
    `ICPM_VEC_SERIAL1, `ICPM_VEC_TIMER2
  };

  // Machine cycle and dispatch state
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic [NSRC-1:0] flag_sample;
  logic [NSRC-1:0] next_flag_sample;
  logic sw_touch;
  logic next_sw_touch;
  logic inprog_hi;
  logic next_inprog_hi;
  logic inprog_lo;
  logic next_inprog_lo;
  logic next_ack_valid;
  icpm_addr_t next_ack_vector;
  icpm_addr_t next_ack_push_pc;

  // Registers, power mode and bus state
  logic [7:0] power_control;
  logic [7:0] next_power_control;
  logic [7:0] intr_enable;
  logic [7:0] next_intr_enable;
  logic [7:0] intr_enable_second;
  logic [7:0] next_intr_enable_second;
  logic [7:0] intr_priority;
  logic [7:0] next_intr_priority;
  logic [7:0] interrupt_priority_second;
  logic [7:0] next_interrupt_priority_second;
  icpm_pm_t pm;
  icpm_pm_t next_pm;
  logic [1:0] rst_cnt;
  logic [1:0] next_rst_cnt;
  logic next_core_reset_hold;
  logic next_cpu_halt;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic ce;
  logic setup;
  logic mapped;
  logic touch_now;
  logic wr_go;
  logic dispatch;
  logic final_cycle;
  logic [9:0] reg_idx;
  logic [15:0] enable_all;
  logic [15:0] priority_all;

  icpm_poll_if #(.NSRC(NSRC)) poll ();

  icpm_arb #(.NSRC(NSRC)) u_arb (
    .p(poll)
  );

  // Power-down freezes everything; only the asynchronous reset clears it
  assign ce = clk_en && !power_control[`ICPM_BIT_POWER_DOWN];

  assign enable_all = {intr_enable_second, intr_enable};
  assign priority_all = {interrupt_priority_second, intr_priority};
  assign poll.inprog_hi = inprog_hi;
  assign poll.inprog_lo = inprog_lo;

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    assign poll.req[g] = flag_sample[g] && enable_all[POS_TAB[g]]
                         && intr_enable[`ICPM_BIT_GLOBAL_ENABLE];
    assign poll.hi[g] = priority_all[POS_TAB[g]];
  end

  assign reg_idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pready && pwrite && !pslverr;
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (reg_idx == `ICPM_IDX_POWER_CONTROL ||
                   reg_idx == `ICPM_IDX_INTR_ENABLE ||
                   reg_idx == `ICPM_IDX_INTR_ENABLE_SECOND ||
                   reg_idx == `ICPM_IDX_INTR_PRIORITY ||
                   reg_idx == `ICPM_IDX_INTR_PRIORITY_SECOND ||
                   reg_idx == `ICPM_IDX_STATUS);
  assign touch_now = psel && mapped &&
                     (reg_idx == `ICPM_IDX_INTR_ENABLE ||
                      reg_idx == `ICPM_IDX_INTR_ENABLE_SECOND ||
                      reg_idx == `ICPM_IDX_INTR_PRIORITY ||
                      reg_idx == `ICPM_IDX_INTR_PRIORITY_SECOND);

  // While idle the core runs no instruction, so every cycle counts as final
  assign final_cycle = instr_last_cycle || (pm == PM_IDLE);
  assign dispatch = (phase == `ICPM_PHASES_LAST) && poll.valid && final_cycle
                    && !instr_blocks_vector && !sw_touch && !touch_now
                    && (pm == PM_RUN || pm == PM_IDLE);

  always_comb begin
    next_phase = (phase == `ICPM_PHASES_LAST) ? 4'h0 : phase + 4'h1;
    next_flag_sample = flag_sample;
    next_sw_touch = sw_touch || touch_now;
    next_inprog_hi = inprog_hi;
    next_inprog_lo = inprog_lo;
    next_ack_valid = 1'b0;
    next_ack_vector = ack_vector;
    next_ack_push_pc = ack_push_pc;
    if (phase == `ICPM_SAMPLE_PHASE) begin
      next_flag_sample = irq_flags;
    end
    if (phase == `ICPM_PHASES_LAST) begin
      next_sw_touch = 1'b0;
    end
    // Only the interrupt return or internal reset frees a level; a plain return is not seen here
    if (return_from_interrupt_instr_exec) begin
      if (inprog_hi) begin
        next_inprog_hi = 1'b0;
      end else begin
        next_inprog_lo = 1'b0;
      end
    end
    // A new grant is applied after the return, so the return never cancels it; internal reset still drops it
    if (dispatch) begin
      next_ack_valid = 1'b1;
      next_ack_vector = VEC_TAB[poll.idx];
      next_ack_push_pc = pc_current;
      if (poll.grant_hi) begin
        next_inprog_hi = 1'b1;
      end else begin
        next_inprog_lo = 1'b1;
      end
    end
    if (internal_reset_req) begin
      next_inprog_hi = 1'b0;
      next_inprog_lo = 1'b0;
      next_ack_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 4'h0;
      flag_sample <= '0;
      sw_touch <= 1'b0;
      inprog_hi <= 1'b0;
      inprog_lo <= 1'b0;
      ack_valid <= 1'b0;
      ack_vector <= 16'h0000;
      ack_push_pc <= 16'h0000;
    end else if (ce) begin
      phase <= next_phase;
      flag_sample <= next_flag_sample;
      sw_touch <= next_sw_touch;
      inprog_hi <= next_inprog_hi;
      inprog_lo <= next_inprog_lo;
      ack_valid <= next_ack_valid;
      ack_vector <= next_ack_vector;
      ack_push_pc <= next_ack_push_pc;
    end
  end

  function automatic logic [31:0] read_mux(input logic [9:0] idx);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (idx)
      `ICPM_IDX_POWER_CONTROL: d[7:0] = power_control;
      `ICPM_IDX_INTR_ENABLE: d[7:0] = intr_enable;
      `ICPM_IDX_INTR_ENABLE_SECOND: d[7:0] = intr_enable_second;
      `ICPM_IDX_INTR_PRIORITY: d[7:0] = intr_priority;
      `ICPM_IDX_INTR_PRIORITY_SECOND: d[7:0] = interrupt_priority_second;
      `ICPM_IDX_STATUS: d[7:0] = {inprog_hi, inprog_lo, 2'h0, pm};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_comb begin
    next_power_control = power_control;
    next_intr_enable = intr_enable;
    next_intr_enable_second = intr_enable_second;
    next_intr_priority = intr_priority;
    next_interrupt_priority_second = interrupt_priority_second;
    next_pm = pm;
    next_rst_cnt = rst_cnt;
    next_core_reset_hold = core_reset_hold;
    next_pready = setup;
    next_pslverr = setup && !mapped;
    next_prdata = prdata;
    if (setup) begin
      next_prdata = (mapped && !pwrite) ? read_mux(reg_idx) : 32'h0000_0000;
    end
    // An enabled grant while idle wakes the core into the service routine
    if (dispatch && pm == PM_IDLE) begin
      next_power_control[`ICPM_BIT_IDLE] = 1'b0;
      next_pm = PM_RUN;
    end
    if (wr_go) begin
      unique case (reg_idx)
        `ICPM_IDX_POWER_CONTROL: begin
          next_power_control = pwdata[7:0];
          if (pwdata[`ICPM_BIT_POWER_DOWN]) begin
            next_pm = PM_PDOWN;
          end else if (pwdata[`ICPM_BIT_IDLE]) begin
            next_pm = PM_IDLE;
          end
        end
        `ICPM_IDX_INTR_ENABLE: next_intr_enable = pwdata[7:0] & `ICPM_MASK_FIRST_ENABLE;
        `ICPM_IDX_INTR_ENABLE_SECOND: next_intr_enable_second = pwdata[7:0] & `ICPM_MASK_SECOND;
        `ICPM_IDX_INTR_PRIORITY: next_intr_priority = pwdata[7:0] & `ICPM_MASK_FIRST_PRIORITY;
        `ICPM_IDX_INTR_PRIORITY_SECOND: begin
          next_interrupt_priority_second = pwdata[7:0] & `ICPM_MASK_SECOND;
        end
        default: next_pm = next_pm;
      endcase
    end
    // Internal reset: registers back to defaults, core held for three machine cycles
    if (internal_reset_req) begin
      next_power_control = `ICPM_RST_REG;
      next_intr_enable = `ICPM_RST_REG;
      next_intr_enable_second = `ICPM_RST_REG;
      next_intr_priority = `ICPM_RST_REG;
      next_interrupt_priority_second = `ICPM_RST_REG;
      next_pm = PM_RSTWAIT;
      next_rst_cnt = 2'h0;
      next_core_reset_hold = 1'b1;
    end else if (pm == PM_RSTWAIT && phase == `ICPM_PHASES_LAST) begin
      next_rst_cnt = rst_cnt + 2'h1;
      if (rst_cnt == `ICPM_RST_MCYCLES - 2'h1) begin
        next_pm = PM_RUN;
        next_core_reset_hold = 1'b0;
      end
    end
    // Halting the core is what keeps its state intact while idle
    next_cpu_halt = (next_pm == PM_IDLE) || (next_pm == PM_PDOWN);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_control <= `ICPM_RST_REG;
      intr_enable <= `ICPM_RST_REG;
      intr_enable_second <= `ICPM_RST_REG;
      intr_priority <= `ICPM_RST_REG;
      interrupt_priority_second <= `ICPM_RST_REG;
      pm <= PM_RUN;
      rst_cnt <= 2'h0;
      core_reset_hold <= 1'b0;
      cpu_halt <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      power_control <= next_power_control;
      intr_enable <= next_intr_enable;
      intr_enable_second <= next_intr_enable_second;
      intr_priority <= next_intr_priority;
      interrupt_priority_second <= next_interrupt_priority_second;
      pm <= next_pm;
      rst_cnt <= next_rst_cnt;
      core_reset_hold <= next_core_reset_hold;
      cpu_halt <= next_cpu_halt;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Straight register bits; the low-voltage supervisor outside keeps running in every mode
  assign osc_stop = power_control[`ICPM_BIT_POWER_DOWN];
  assign serial1_baud_double = power_control[`ICPM_BIT_SERIAL1_DOUBLE];
  assign serial2_baud_double = power_control[`ICPM_BIT_SERIAL2_DOUBLE];
  assign low_voltage_reset_disable = power_control[`ICPM_BIT_LVR_DISABLE];
  assign adc_interrupt_enable = power_control[`ICPM_BIT_ADC_INT_ENABLE];
  assign serial2_receive_clock_flag = power_control[`ICPM_BIT_SERIAL2_RX_CLK];
  assign serial2_transmit_clock_flag = power_control[`ICPM_BIT_SERIAL2_TX_CLK];
endmodule
`default_nettype wire

/* icpm_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module icpm_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instr_last_cycle,
  input wire logic instr_blocks_vector,
  input wire icpm_pkg::icpm_addr_t pc_current,
  input wire logic internal_reset_req,
  input wire logic ack_valid,
  input wire icpm_pkg::icpm_addr_t ack_vector,
  input wire icpm_pkg::icpm_addr_t ack_push_pc,
  input wire logic cpu_halt,
  input wire logic osc_stop,
  input wire logic core_reset_hold,
  input wire logic serial1_baud_double
);
  import icpm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && !penable && clk_en && !osc_stop |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_call_gate: assert property (ack_valid |-> $past(instr_last_cycle) && !$past(instr_blocks_vector))
    else $error("call outside final cycle or while blocked");
  a_call_space: assert property (ack_valid |-> ##1 (!ack_valid) [*8])
    else $error("two calls in one machine cycle");
  a_vector_form: assert property (ack_valid |-> ack_vector[2:0] == 3'h3 && ack_vector <= 16'h004b)
    else $error("vector outside table");
  a_push_pc: assert property (ack_valid |-> ack_push_pc == $past(pc_current))
    else $error("pushed address wrong");
  a_pdown_halt: assert property (osc_stop |-> ##[0:2] cpu_halt)
    else $error("core runs in power-down");
  a_pdown_no_call: assert property (osc_stop && $past(osc_stop) |-> !ack_valid)
    else $error("call in power-down");
  a_intrst_clear: assert property (internal_reset_req |=> core_reset_hold && !serial1_baud_double && !osc_stop)
    else $error("internal reset did not clear");
  a_intrst_len: assert property (internal_reset_req |=> core_reset_hold [*8] ##[4:40] !core_reset_hold)
    else $error("restart delay wrong");
  a_wake_call: assert property (ack_valid |-> ##[0:2] !cpu_halt)
    else $error("call did not end idle");
endmodule
`default_nettype wire

/* icpm_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icpm_src_model #(
  parameter logic [9:0][15:0] vectors = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] raise,
  input wire logic [9:0] lower,
  input wire logic [1:0] mode,
  input wire logic ack_valid,
  input wire icpm_pkg::icpm_addr_t ack_vector,
  output logic [9:0] irq_flags,
  output logic instr_last_cycle,
  output icpm_pkg::icpm_addr_t pc_current
);
  import icpm_pkg::*;
  logic [9:0] served;
  logic [2:0] cnt;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      served[i] = ack_valid && ack_vector == vectors[i];
    end
  end
  // Flags act as level sources: held until their own call is taken or lower drops them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_flags <= '0;
      cnt <= '0;
      instr_last_cycle <= 1'b0;
      pc_current <= 16'h0100;
    end else begin
      irq_flags <= (irq_flags | raise) & ~lower & ~served;
      cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      pc_current <= pc_current + 16'h0001;
      // Slow mode: multi-cycle instructions end only one clock in five
      instr_last_cycle <= (mode == 2'h0) || (mode == 2'h1 && cnt == 3'h0);
    end
  end
endmodule
`default_nettype wire

/* icpm_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module icpm_tb_top;
  import icpm_pkg::*;
  localparam logic [9:0][15:0] vec = {16'h002b, 16'h0023, 16'h0033, 16'h001b, 16'h003b,
    16'h0013, 16'h0043, 16'h000b, 16'h004b, 16'h0003};
  localparam logic [11:0] adr_power = 12'h21c, adr_en2 = 12'h29c, adr_en = 12'h2a0, adr_pri2 = 12'h2dc;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic instr_blocks_vector = 1'b0, return_from_interrupt_instr_exec = 1'b0, internal_reset_req = 1'b0;
  logic [9:0] raise = '0, lower = '0;
  logic [1:0] mode = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, got, ack_valid, cpu_halt, osc_stop, core_reset_hold, instr_last_cycle;
  logic serial1_baud_double, serial2_baud_double, low_voltage_reset_disable, adc_interrupt_enable;
  logic serial2_receive_clock_flag, serial2_transmit_clock_flag;
  logic [9:0] irq_flags;
  icpm_addr_t pc_current, ack_vector, ack_push_pc;
  int fails = 0, check_count = 0;

  always #2.5 clk = ~clk;

  icpm_top uut (.clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq_flags, .instr_last_cycle, .instr_blocks_vector, .return_from_interrupt_instr_exec, .pc_current,
    .internal_reset_req, .ack_valid, .ack_vector, .ack_push_pc, .cpu_halt, .osc_stop,
    .core_reset_hold, .serial1_baud_double, .serial2_baud_double, .low_voltage_reset_disable,
    .adc_interrupt_enable, .serial2_receive_clock_flag, .serial2_transmit_clock_flag);
  icpm_src_model #(.vectors(vec)) src (.clk, .rst, .raise, .lower, .mode, .ack_valid,
    .ack_vector, .irq_flags, .instr_last_cycle, .pc_current);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ack(input int lim);
    got = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (ack_valid === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  task automatic flag(input logic [9:0] m);
    @(posedge clk);
    raise <= m;
    @(posedge clk);
    raise <= '0;
  endtask
  task automatic ret_intr();
    @(posedge clk);
    return_from_interrupt_instr_exec <= 1'b1;
    @(posedge clk);
    return_from_interrupt_instr_exec <= 1'b0;
  endtask

  task automatic t_regs();
    apb(0, adr_power, 8'h00);
    check("power reset", rd, 32'h0);
    apb(1, adr_power, 8'hfc);
    @(posedge clk);
    check("power outs", {serial1_baud_double, serial2_baud_double, low_voltage_reset_disable,
      adc_interrupt_enable, serial2_receive_clock_flag, serial2_transmit_clock_flag}, 6'h3f);
    check("no halt", {cpu_halt, osc_stop}, 2'h0);
    apb(1, adr_pri2, 8'hff);
    apb(0, adr_pri2, 8'h00);
    check("priority second", rd, 32'h93);
    apb(1, adr_pri2, 8'h00);
    apb(0, 12'h004, 8'h00);
    check("unmapped error", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1, 12'h21d, 8'h00);
    check("misaligned", er, 1'b1);
    apb(0, adr_power, 8'h00);
    check("write ignored", rd, 32'hfc);
    apb(1, adr_power, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_order();
    apb(1, adr_en, 8'hbf);
    apb(1, adr_en2, 8'h93);
    flag(10'h3ff);
    for (int i = 0; i < 10; i++) begin
      wait_ack(60);
      check("polled vector", {got, ack_vector}, {1'b1, vec[i]});
      ret_intr();
    end
    apb(1, adr_pri2, 8'h01);
    flag(10'h081);
    wait_ack(60);
    check("high first", ack_vector, vec[7]);
    wait_ack(60);
    check("low held off", got, 1'b0);
    ret_intr();
    wait_ack(60);
    check("low after return", {got, ack_vector}, {1'b1, vec[0]});
    ret_intr();
    apb(1, adr_pri2, 8'h00);
    $display("test order done");
  endtask
  task automatic t_block();
    @(posedge clk);
    instr_blocks_vector <= 1'b1;
    flag(10'h004);
    wait_ack(40);
    check("blocked", got, 1'b0);
    lower <= 10'h004;
    @(posedge clk);
    lower <= '0;
    // Let a fresh sample of the dropped flag land before the block ends
    repeat (13) @(posedge clk);
    instr_blocks_vector <= 1'b0;
    wait_ack(40);
    check("not remembered", got, 1'b0);
    mode <= 2'h2;
    flag(10'h004);
    wait_ack(40);
    check("not final cycle", got, 1'b0);
    mode <= 2'h1;
    wait_ack(100);
    check("slow final", {got, ack_vector}, {1'b1, vec[2]});
    ret_intr();
    mode <= 2'h0;
    apb(1, adr_en, 8'h3f);
    flag(10'h010);
    wait_ack(40);
    check("global off", got, 1'b0);
    apb(1, adr_en, 8'hbf);
    wait_ack(40);
    check("global on", {got, ack_vector}, {1'b1, vec[4]});
    ret_intr();
    clk_en <= 1'b0;
    flag(10'h100);
    wait_ack(40);
    check("frozen", got, 1'b0);
    clk_en <= 1'b1;
    wait_ack(40);
    check("thawed", {got, ack_vector}, {1'b1, vec[8]});
    ret_intr();
    $display("test block done");
  endtask
  task automatic t_idle();
    apb(1, adr_power, 8'h01);
    repeat (3) @(posedge clk);
    check("idle halt", cpu_halt, 1'b1);
    apb(0, adr_en, 8'h00);
    check("kept in idle", rd, 32'hbf);
    flag(10'h040);
    wait_ack(40);
    check("wake call", {got, ack_vector}, {1'b1, vec[6]});
    repeat (3) @(posedge clk);
    check("awake", cpu_halt, 1'b0);
    apb(0, adr_power, 8'h00);
    check("idle bit cleared", rd, 32'h0);
    ret_intr();
    $display("test idle done");
  endtask
  task automatic t_intrst();
    int n = 0;
    apb(1, adr_power, 8'h81);
    @(posedge clk);
    internal_reset_req <= 1'b1;
    @(posedge clk);
    internal_reset_req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (core_reset_hold === 1'b1 && n < 60);
    check("restart delay", (n >= 24 && n <= 37), 1'b1);
    check("idle ended", cpu_halt, 1'b0);
    apb(0, adr_power, 8'h00);
    check("cleared", rd, 32'h0);
    $display("test internal reset done");
  endtask
  task automatic t_pdown();
    apb(1, adr_en, 8'hbf);
    apb(1, adr_power, 8'h23);
    repeat (3) @(posedge clk);
    check("stopped", {osc_stop, cpu_halt}, 2'h3);
    flag(10'h001);
    wait_ack(60);
    check("no wake", got, 1'b0);
    check("detector kept", low_voltage_reset_disable, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (30) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset exit", {osc_stop, cpu_halt}, 2'h0);
    $display("test power-down done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_order();
    t_block();
    t_idle();
    t_intrst();
    t_pdown();
    report_and_stop();
  end
endmodule
bind icpm_top icpm_asserts u_chk (.clk, .rst, .clk_en, .psel, .penable, .paddr, .pready, .pslverr,
  .instr_last_cycle, .instr_blocks_vector, .pc_current, .internal_reset_req, .ack_valid,
  .ack_vector, .ack_push_pc, .cpu_halt, .osc_stop, .core_reset_hold, .serial1_baud_double);
`default_nettype wire
